// ### rtl/nand_host.sv
// Purpose: host sequencer driving a byte-wide nand flash over its pins
// Assumes: one device, ready_busy_output synchronised here
// Notes:   one operation at a time; software-like policy in logic
// Function
// - during power-up busy, only reset or status read are issued
// - only defined command codes ever leave this host
// - while device busy, issue nothing but status read or reset
// - after serial input command, follow only with program confirm or reset
// - whole pages of a block programmed in consecutive order, no page skipped; segment programs are not order-checked
// - host never reads status mid-read; read data out follows the ready pin
// - eight partial segments; four 512-byte main segments
// - four 16-byte spare segments from column 2048
// - host loads ones outside the programmed segment
// - host is given factory bad blocks on bad_set and never erases them
// - program failure: host bars failing block
// - erase failure: host marks block bad
// - pass/fail bits trusted only with ready bit set
`timescale 1ns/10ps
`include "nand_host_regs.svh"
module nand_host import nand_host_pkg::*; #(
  parameter int BLOCKS = 2048,
  parameter int PAGES  = 64
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // user request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire op_t         req_op,
  input  wire logic [10:0] req_block,
  input  wire logic [5:0]  req_page,
  input  wire logic [2:0]  req_seg,
  input  wire logic        req_seg_en,
  input  wire logic        bad_set,
  input  wire logic [10:0] bad_block,
  // user data
  input  wire logic [7:0]  wr_data,
  output logic             wr_take,
  output logic [7:0]       rd_data,
  output logic             rd_valid,
  // result
  output logic             done,
  output logic [2:0]       result,
  output logic [7:0]       status,
  // pins
  output logic             cle,
  output logic             ale,
  output logic             ce_n,
  output logic             we_n,
  output logic             re_n,
  output logic             wp_n,
  input  wire logic        write_protect,
  output logic [7:0]       io_out,
  output logic             io_oe,
  input  wire logic [7:0]  io_in,
  input  wire logic        ready_busy_output
);
  ////////////////////////////////////////////////////////////
  state_t      state, next_state;
  op_t         op, next_op;
  logic [11:0] cnt, next_cnt;
  logic [2:0]  sub, next_sub;
  logic [10:0] blk, next_blk;
  logic [5:0]  pg, next_pg;
  logic [2:0]  seg, next_seg;
  logic        seg_en, next_seg_en;
  logic [7:0]  io_o, next_io_o;
  logic        cle_r, next_cle, ale_r, next_ale, we_r, next_we, re_r, next_re, oe_r, next_oe;
  logic [7:0]  rdd, next_rdd, stat, next_stat;
  logic        rdv, next_rdv, dn, next_dn, take, next_take;
  logic [2:0]  res, next_res;
  logic        rb_m, rb;
  logic [7:0]  io_m, io_s;
  logic [BLOCKS-1:0] bad;
  logic [5:0]  next_page [BLOCKS];
  logic [BLOCKS-1:0] page_known;
  logic [5:0]  due_page;
  logic        wp_m, wp_s;

  // a byte phase lasts STROBE_CYC + 1 clocks; sub counts it
  function automatic logic [11:0] seg_lo(input logic [2:0] s);
    seg_lo = s[2] ? 12'(`PAGE_MAIN + 12'(s[1:0]) * `SEG_SPARE_BYTES)
                  : 12'(12'(s[1:0]) * `SEG_MAIN_BYTES);
  endfunction
  function automatic logic in_seg(input logic [11:0] c, input logic [2:0] s);
    in_seg = (c >= seg_lo(s)) && (c < 12'(seg_lo(s) + (s[2] ? `SEG_SPARE_BYTES : `SEG_MAIN_BYTES)));
  endfunction

  ////////////////////////////////////////////////////////////
  // pin inputs through two flops; first stage read only by second
  always_ff @(posedge clk) begin
    rb_m <= ready_busy_output;
    rb   <= rb_m;
    io_m <= io_in;
    io_s <= io_m;
    wp_m <= write_protect;
    wp_s <= wp_m;
  end

  ////////////////////////////////////////////////////////////
  // bad-block table and next-page record
  always_ff @(posedge clk) begin
    if (reset) begin
      bad        <= '0;
      page_known <= '0;
    end else begin
      if (bad_set)
        bad[bad_block] <= 1'b1;
      // besides bad_set, only a device failure condemns a block; policy refusals do not
      if (dn && res == 3'h1 && (op == op_prog || op == op_erase))
        bad[blk] <= 1'b1;
      if (dn && res == 3'h0 && ((op == op_prog && !seg_en) || op == op_erase))
        page_known[blk] <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (dn && res == 3'h0 && op == op_prog && !seg_en)
      next_page[blk] <= 6'(pg + 6'h01);
    else if (dn && res == 3'h0 && op == op_erase)
      next_page[blk] <= 6'h00;
  end

  ////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state; next_op = op; next_cnt = cnt; next_sub = sub;
    next_blk = blk; next_pg = pg; next_seg = seg; next_seg_en = seg_en;
    // strobes rest high unless a state asks for a low phase
    next_io_o = io_o; next_cle = cle_r; next_ale = ale_r; next_we = 1'b0;
    next_re = 1'b0; next_oe = oe_r; next_rdd = rdd; next_stat = stat;
    next_rdv = 1'b0; next_dn = 1'b0; next_take = 1'b0; next_res = res;
    // sub: 0 setup, 1 strobe low, 2 to STROBE_CYC strobe high
    if (state != s_idle && state != s_init && state != s_wait && state != s_done)
      next_sub = (sub == 3'(`STROBE_CYC)) ? 3'h0 : 3'(sub + 3'h1);
    case (state)
      s_init: begin
        // wait for power-up busy to end, then send reset
        if (rb) begin
          next_op = op_reset; next_io_o = `CMD_RESET; next_cle = 1'b1; next_oe = 1'b1;
          next_sub = 3'h0; next_state = s_cmd;
        end
      end
      s_idle: begin
        if (req_valid) begin
          next_blk = req_block; next_pg = req_page; next_seg = req_seg; next_seg_en = req_seg_en;
          next_res = 3'h0;
          next_op = req_op;
          if ((req_op == op_prog || req_op == op_erase) && bad[req_block]) begin
            next_res = 3'h2; next_dn = 1'b1; next_state = s_done;
          end else if (req_op == op_prog && !req_seg_en && req_page != due_page) begin
            next_res = 3'h3; next_dn = 1'b1; next_state = s_done;
          end else if ((req_op == op_prog || req_op == op_erase) && !wp_s) begin
            next_res = 3'h4; next_dn = 1'b1; next_state = s_done;
          end else if (req_op == op_none) begin
            next_res = 3'h5; next_dn = 1'b1; next_state = s_done;
          end else begin
            next_op = req_op; next_cle = 1'b1; next_oe = 1'b1; next_sub = 3'h0; next_state = s_cmd;
            case (req_op)
              op_read:  next_io_o = `CMD_READ;
              op_prog:  next_io_o = `CMD_PROG;
              op_erase: next_io_o = `CMD_ERASE;
              op_reset: next_io_o = `CMD_RESET;
              default:  next_io_o = `CMD_STATUS;
            endcase
          end
        end
      end
      s_cmd: begin
        next_we = (sub == 3'h0);
        if (sub == 3'(`STROBE_CYC)) begin
          next_cle = 1'b0; next_cnt = 12'h000;
          if (op == op_reset || op == op_status) begin
            next_state = (op == op_status) ? s_stat_rd : s_wait;
            next_oe = 1'b0;
          end else begin
            next_ale = 1'b1; next_state = s_addr;
            // whole page always loaded from column zero, so segment data stays aligned
            next_io_o = (op == op_erase) ? {blk[1:0], 6'h00} : 8'h00;
            if (op == op_erase) next_cnt = 12'h002;
          end
        end
      end
      s_addr: begin
        // five cycles: col lo, col hi, row lo, row mid, row hi (erase: row bytes only); never a sixth
        next_we = (sub == 3'h0);
        if (sub == 3'(`STROBE_CYC)) begin
          next_cnt = 12'(cnt + 12'h001);
          case (cnt)
            12'h000: next_io_o = 8'h00;
            12'h001: next_io_o = {blk[1:0], pg};
            12'h002: next_io_o = blk[9:2];
            12'h003: next_io_o = {7'h00, blk[10]};
            default: next_io_o = 8'h00;
          endcase
          if (cnt == 12'h004) begin
            next_ale = 1'b0; next_cnt = 12'h000;
            if (op == op_prog) begin
              next_state = s_data; next_take = 1'b1;
              next_io_o = (!seg_en || in_seg(12'h000, seg)) ? wr_data : 8'hFF;
            end else begin
              next_cle = 1'b1; next_state = s_cmd2;
              next_io_o = (op == op_erase) ? `CMD_ERASE_GO : `CMD_READ_GO;
            end
          end
        end
      end
      s_data: begin
        if (op == op_prog) next_we = (sub == 3'h0); else next_re = (sub == 3'h0);
        if (sub == 3'(`STROBE_CYC)) begin
          next_cnt = 12'(cnt + 12'h001);
          if (op == op_read) begin next_rdv = 1'b1; next_rdd = io_s; end
          if (cnt == `PAGE_TOTAL - 12'h001) begin
            if (op == op_prog) begin
              next_cle = 1'b1; next_state = s_cmd2; next_io_o = `CMD_PROG_GO;
              next_cnt = 12'h000;
            end else begin
              next_dn = 1'b1; next_state = s_done;
            end
          end else if (op == op_prog) begin
            next_take = 1'b1;
            next_io_o = (!seg_en || in_seg(12'(cnt + 12'h001), seg)) ? wr_data : 8'hFF;
          end
        end
      end
      s_cmd2: begin
        next_we = (sub == 3'h0);
        if (sub == 3'(`STROBE_CYC)) begin
          next_cle = 1'b0; next_oe = 1'b0; next_state = s_wait;
        end
      end
      s_wait: begin
        // nothing issued while busy; poll pin, then status after program or erase
        if (rb && cnt == 12'h004) begin
          next_cnt = 12'h000; next_sub = 3'h0;
          if (op == op_read) begin next_state = s_data; next_oe = 1'b0; end
          else if (op == op_reset) begin next_dn = 1'b1; next_state = s_done; end
          else begin
            next_state = s_stat_cmd; next_cle = 1'b1; next_oe = 1'b1; next_io_o = `CMD_STATUS;
          end
        end else if (cnt != 12'h004) next_cnt = 12'(cnt + 12'h001);
      end
      s_stat_cmd: begin
        next_we = (sub == 3'h0);
        if (sub == 3'(`STROBE_CYC)) begin next_cle = 1'b0; next_oe = 1'b0; next_state = s_stat_rd; end
      end
      s_stat_rd: begin
        next_re = (sub == 3'h0);
        if (sub == 3'(`STROBE_CYC)) begin
          next_stat = io_s;
          // fail bit only trusted once ready
          if (io_s[`ST_READY_BIT]) begin
            if (io_s[`ST_FAIL_BIT] && op != op_status) next_res = 3'h1;
            next_dn = 1'b1; next_state = s_done;
          end
        end
      end
      s_done: begin
        next_state = s_idle;
      end
      default: next_state = s_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= s_init; op <= op_none; cnt <= 12'h000; sub <= 3'h0;
      blk <= 11'h000; pg <= 6'h00; seg <= 3'h0; seg_en <= 1'b0;
      io_o <= 8'h00; cle_r <= 1'b0; ale_r <= 1'b0; we_r <= 1'b1; re_r <= 1'b1; oe_r <= 1'b0;
      rdd <= 8'h00; stat <= 8'h00; rdv <= 1'b0; dn <= 1'b0; take <= 1'b0; res <= 3'h0;
    end else begin
      state <= next_state; op <= next_op; cnt <= next_cnt; sub <= next_sub;
      blk <= next_blk; pg <= next_pg; seg <= next_seg; seg_en <= next_seg_en;
      io_o <= next_io_o; cle_r <= next_cle; ale_r <= next_ale; we_r <= !next_we; re_r <= !next_re;
      oe_r <= next_oe; rdd <= next_rdd; stat <= next_stat; rdv <= next_rdv; dn <= next_dn;
      take <= next_take; res <= next_res;
    end
  end

  ////////////////////////////////////////////////////////////
  assign req_ready = (state == s_idle);
  // a block not seen since reset may only be opened at page zero
  assign due_page  = page_known[req_block] ? next_page[req_block] : 6'h00;
  assign cle = cle_r;
  assign ale = ale_r;
  assign ce_n = 1'b0;
  assign we_n = we_r;
  assign re_n = re_r;
  assign wp_n = !reset; // protects array while host in reset
  assign io_out = io_o;
  assign io_oe = oe_r;
  assign rd_data = rdd;
  assign rd_valid = rdv;
  assign wr_take = take;
  assign done = dn;
  assign result = res;
  assign status = stat;

  ////////////////////////////////////////////////////////////
  a_init_cmds: assert property (@(posedge clk) disable iff (reset)
    (state == s_init) |=> (state == s_init) || (state == s_cmd && op == op_reset && io_o == `CMD_RESET))
    else $error("bad command during init");
  a_busy_quiet: assert property (@(posedge clk) disable iff (reset)
    (state == s_wait) |=> !cle_r || io_o == `CMD_STATUS) else $error("command while busy");
  a_prog_follow: assert property (@(posedge clk) disable iff (reset)
    (state == s_cmd2 && op == op_prog) |-> io_o == `CMD_PROG_GO) else $error("bad follow-up");
  a_wp_refuse: assert property (@(posedge clk) disable iff (reset)
    (state == s_idle && req_valid && req_op == op_erase && !wp_s && !bad[req_block]) |=> res == 3'h4)
    else $error("protect ignored");
  a_bad_skip: assert property (@(posedge clk) disable iff (reset)
    (state == s_idle && req_valid && req_op == op_erase && bad[req_block]) |=> dn && res == 3'h2)
    else $error("erase of bad block");
  a_page_order: assert property (@(posedge clk) disable iff (reset)
    (state == s_idle && req_valid && req_op == op_prog && !req_seg_en && !bad[req_block] &&
     req_page != due_page) |=> res == 3'h3) else $error("page order");
  a_fill_ones: assert property (@(posedge clk) disable iff (reset)
    (state == s_data && op == op_prog && seg_en && sub == 3'h0 && !in_seg(cnt, seg) && !cle_r) |-> io_o == 8'hFF)
    else $error("non-ones outside segment");
  a_fail_ready: assert property (@(posedge clk) disable iff (reset)
    (state == s_stat_rd && sub == 3'(`STROBE_CYC) && !io_s[`ST_READY_BIT]) |=> !dn)
    else $error("result without ready");
  a_strobe_exclusive: assert property (@(posedge clk) disable iff (reset)
    !(!we_r && !re_r)) else $error("both strobes low");
  c_partial: cover property (@(posedge clk) disable iff (reset) dn && op == op_prog && seg_en && res == 3'h0);
  c_prog: cover property (@(posedge clk) disable iff (reset) dn && op == op_prog && res == 3'h0);
  c_erase: cover property (@(posedge clk) disable iff (reset) dn && op == op_erase);
  c_read: cover property (@(posedge clk) disable iff (reset) dn && op == op_read);
endmodule // nand_host

// ### rtl/nand_host_pkg.sv
// Purpose: types for the nand host sequencer
// Assumes: nothing
// Notes:   operations and states
package nand_host_pkg;
  typedef enum logic [2:0] {op_none, op_read, op_prog, op_erase, op_reset, op_status} op_t;
  typedef enum {s_init, s_idle, s_cmd, s_addr, s_data, s_cmd2, s_wait, s_stat_cmd, s_stat_rd, s_done} state_t;
endpackage

// ### rtl/nand_host_regs.svh
// Purpose: constants for the nand host sequencer
// Assumes: 125 MHz clock
// Notes:   command codes, geometry and pin timing counts
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH
`define CMD_READ        8'h00
`define CMD_READ_GO     8'h30
`define CMD_PROG        8'h80
`define CMD_PROG_GO     8'h10
`define CMD_ERASE       8'h60
`define CMD_ERASE_GO    8'hD0
`define CMD_STATUS      8'h70
`define CMD_RESET       8'hFF
`define ST_FAIL_BIT     0
`define ST_READY_BIT    6
`define ST_WP_BIT       7
`define PAGE_MAIN       12'h800
`define PAGE_TOTAL      12'h840
`define SEG_MAIN_BYTES  12'h200
`define SEG_SPARE_BYTES 12'h010
`define STROBE_NS       24
`define STROBE_CYC      ((`STROBE_NS + 7) / 8)
`endif

// ### testbench/nand_dev_model.sv
// Purpose: behavioural byte-wide nand device facing the host sequencer
// Assumes: open-drain ready pin pulled up; sparse array, unwritten bytes read as ones
// Notes:   host protocol slips are counted in viol, not stopped, so the bench can report them
`timescale 1ns/10ps
module nand_dev_model #(
  parameter int BUSY_NS = 800,
  parameter int INIT_NS = 2000
) (
  // pins from host
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       ce_n,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] io_bus,
  // fault injection
  input  wire logic       fail_next,
  // pins to host
  output logic [7:0]      dq,
  output logic            dq_oe,
  output logic            rb
);
  logic [7:0] mem [int];
  logic [7:0] pg [0:2111];
  int         last_pg [int];
  int         col, row, acnt, viol, tok;
  logic [7:0] cmd, first_cmd;
  logic       busy, stat_mode, failed;
  ////////////////////////////////////////////////////////////////////////////////
  // a later reset bumps tok, so a stale timer cannot clear busy
  task automatic go_busy(input int ns);
    int t;
    tok++;
    t = tok;
    busy = 1;
    fork
      begin
        #(ns);
        if (t == tok) busy = 0;
      end
    join_none
  endtask
  initial begin
    {tok, viol, col, row, acnt} = '0;
    {cmd, first_cmd, dq} = '0;
    {stat_mode, failed} = '0;
    go_busy(INIT_NS);
  end
  assign rb    = !busy;
  assign dq_oe = !ce_n && !re_n;
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge re_n) if (!ce_n) dq = stat_mode ? {wp_n, !busy, !busy, 4'h0, failed} : pg[col % 2112];
  always @(posedge re_n) if (!ce_n && !stat_mode) col++;
  always @(posedge we_n) if (!ce_n) begin
    if (cle) begin
      if (first_cmd == 8'h00) first_cmd = io_bus;
      if (busy && !(io_bus inside {8'h70, 8'hFF})) viol++;
      if (cmd == 8'h80 && !(io_bus inside {8'h10, 8'hFF})) viol++;
      acnt = 0;
      case (io_bus)
        8'h00: stat_mode = 0;
        8'h30: begin
          for (int i = 0; i < 2112; i++) pg[i] = mem.exists(row * 4096 + i) ? mem[row * 4096 + i] : 8'hFF;
          go_busy(BUSY_NS);
        end
        8'h80: foreach (pg[i]) pg[i] = 8'hFF;
        8'h10: begin
          if (last_pg.exists(row / 64) && row % 64 < last_pg[row / 64]) viol++;
          last_pg[row / 64] = row % 64;
          // cells only go from one to zero, so repeated segments merge
          if (wp_n && !fail_next) for (int i = 0; i < 2112; i++)
            mem[row * 4096 + i] = pg[i] & (mem.exists(row * 4096 + i) ? mem[row * 4096 + i] : 8'hFF);
          failed = fail_next;
          go_busy(BUSY_NS);
        end
        8'h60: acnt = 0;
        8'hD0: begin
          if (wp_n && !fail_next) foreach (mem[k]) if (k / 262144 == row / 64) mem[k] = 8'hFF;
          failed = fail_next;
          go_busy(BUSY_NS);
        end
        8'h70: stat_mode = 1;
        8'hFF: begin
          stat_mode = 0;
          failed = 0;
          go_busy(BUSY_NS / 4);
        end
        default: viol++;
      endcase
      cmd = io_bus;
    end else if (ale) begin
      if (cmd == 8'h60 && acnt < 3) row[8 * acnt +: 8] = io_bus;
      else if (cmd != 8'h60 && acnt < 2) col[8 * acnt +: 8] = io_bus;
      else if (cmd != 8'h60 && acnt < 5) row[8 * (acnt - 2) +: 8] = io_bus;
      acnt++;
    end else if (cmd == 8'h80 && col < 2112) begin
      pg[col] = io_bus;
      col++;
    end
  end
endmodule // nand_dev_model

// ### testbench/tb_nand_host.sv
// Purpose: self-checking bench for the nand host sequencer
// Assumes: behavioural device model on the pins, 125 MHz clock
// Notes:   page moves cost thousands of cycles each, so only six pages travel
`timescale 1ns/10ps
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module tb_nand_host import nand_host_pkg::*;;
  localparam int LIMIT = 70000;
  logic        clk, reset, req_valid, req_ready, req_seg_en, bad_set, wr_take, rd_valid, done;
  logic        cle, ale, ce_n, we_n, re_n, wp_n, io_oe, write_protect, rb, dq_oe, fail_next;
  op_t         req_op;
  logic [10:0] req_block, bad_block;
  logic [5:0]  req_page;
  logic [2:0]  req_seg, result;
  logic [7:0]  wr_data, rd_data, status, io_out, io_in, dq, salt;
  int          fails, check_count, cyc, wr_idx;
  logic [7:0]  rdq [$];
  ////////////////////////////////////////////////////////////////////////////////
  assign io_in   = io_oe ? io_out : (dq_oe ? dq : ~dq);
  assign wr_data = wr_idx[7:0] ^ salt;
  nand_host u_nand_host (.clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_block(req_block), .req_page(req_page), .req_seg(req_seg), .req_seg_en(req_seg_en), .bad_set(bad_set),
    .bad_block(bad_block), .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
    .done(done), .result(result), .status(status), .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n), .re_n(re_n),
    .wp_n(wp_n), .write_protect(write_protect), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
    .ready_busy_output(rb));
  nand_dev_model #(.BUSY_NS(800), .INIT_NS(2000)) u_nand_dev_model (.cle(cle), .ale(ale), .ce_n(ce_n),
    .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_bus(io_in), .fail_next(fail_next), .dq(dq), .dq_oe(dq_oe), .rb(rb));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    #1;
    if (wr_take === 1'b1) wr_idx++;
  end
  always @(negedge clk) if (rd_valid === 1'b1) rdq.push_back(rd_data);
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic run_op(input op_t op, input int blk, page, seg, input logic en);
    int n;
    rdq.delete();
    wr_idx = 0;
    n = 0;
    @(posedge clk) #1;
    req_valid = 1;
    req_op = op;
    req_block = blk[10:0];
    req_page = page[5:0];
    req_seg = seg[2:0];
    req_seg_en = en;
    while (req_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1;
    req_valid = 0;
    while (done !== 1'b1 && n < LIMIT) begin
      @(posedge clk) #1;
      n++;
    end
    // last read byte is queued on the falling edge after done
    @(posedge clk) #1;
  endtask
  // offsets cover a host that takes only segment bytes as well as one taking the whole page
  task automatic check_page(input int lo0, hi0, off0, lo1, hi1, off1, input logic [7:0] s0, s1);
    logic [7:0] e;
    `CHK("page length", 2112, rdq.size())
    foreach (rdq[i]) begin
      e = (i >= lo0 && i < hi0) ? 8'(i - off0) ^ s0 : (i >= lo1 && i < hi1) ? 8'(i - off1) ^ s1 : 8'hFF;
      `CHK("read byte", e, rdq[i])
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_init();
    run_op(op_none, 0, 0, 0, 0);
    `CHK("undefined op result", 3'h5, result)
    `CHK("first command", 8'hFF, u_nand_dev_model.first_cmd)
    $display("test init done");
  endtask
  task automatic t_full();
    salt = 8'h3C;
    run_op(op_prog, 1, 0, 0, 0);
    `CHK("program result", 3'h0, result)
    `CHK("bytes taken", 2112, wr_idx)
    run_op(op_read, 1, 0, 0, 0);
    check_page(0, 2112, 0, 0, 0, 0, 8'h3C, 8'h00);
    run_op(op_prog, 1, 2, 0, 0);
    `CHK("page skip result", 3'h3, result)
    $display("test full page done");
  endtask
  task automatic t_partial();
    int off0, off1;
    salt = 8'hA5;
    run_op(op_prog, 2, 0, 1, 1);
    off0 = (wr_idx == 512) ? 512 : 0;
    `CHK("main segment result", 3'h0, result)
    salt = 8'h5A;
    run_op(op_prog, 2, 0, 5, 1);
    off1 = (wr_idx == 16) ? 2064 : 0;
    `CHK("spare segment result", 3'h0, result)
    run_op(op_read, 2, 0, 0, 0);
    check_page(512, 1024, off0, 2064, 2080, off1, 8'hA5, 8'h5A);
    $display("test partial done");
  endtask
  task automatic t_fault();
    @(posedge clk) #1;
    bad_set = 1;
    bad_block = 11'h003;
    @(posedge clk) #1;
    bad_set = 0;
    run_op(op_erase, 3, 0, 0, 0);
    `CHK("bad block erase", 3'h2, result)
    fail_next = 1;
    run_op(op_erase, 4, 0, 0, 0);
    fail_next = 0;
    `CHK("erase fail result", 3'h1, result)
    `CHK("status ready", 1'b1, status[6])
    `CHK("status fail", 1'b1, status[0])
    run_op(op_erase, 4, 0, 0, 0);
    `CHK("failed block erase", 3'h2, result)
    write_protect = 0;
    repeat (4) @(posedge clk) #1;
    run_op(op_prog, 5, 0, 0, 0);
    `CHK("protected program", 3'h4, result)
    run_op(op_erase, 1, 0, 0, 0);
    `CHK("protected erase", 3'h4, result)
    write_protect = 1;
    repeat (4) @(posedge clk) #1;
    run_op(op_erase, 1, 0, 0, 0);
    `CHK("erase result", 3'h0, result)
    run_op(op_read, 1, 0, 0, 0);
    check_page(0, 0, 0, 0, 0, 0, 8'h00, 8'h00);
    $display("test faults done");
  endtask
  initial begin
    {clk, req_valid, req_seg_en, bad_set, fail_next} = '0;
    {req_block, bad_block, req_page, req_seg, salt} = '0;
    {fails, check_count, cyc, wr_idx} = '0;
    req_op = op_none;
    write_protect = 1;
    reset = 1;
    repeat (2) @(posedge clk) #1;
    reset = 0;
    t_init();
    t_full();
    t_partial();
    t_fault();
    `CHK("host protocol slips", 0, u_nand_dev_model.viol)
    conclude();
  end
endmodule // tb_nand_host
